// ===== pkg/lrs_map.vh
// Constants for the LCD RAM access and scroll command block
`ifndef LRS_MAP_VH
`define LRS_MAP_VH
// Times in ns at a 270 kHz oscillator
`define LRS_T_LONG_NS 1530000
`define LRS_T_SHORT_NS 39000
`define LRS_T_DATA_NS 43000
`define LRS_CLK_NS 25
`define LRS_SPACE_CODE 8'h20
`define LRS_AC_ZERO 7'h00
`define LRS_SQ_MAX 6'h30
`define LRS_DD_DEPTH 128
`define LRS_CG_DEPTH 64
`define LRS_SEG_DEPTH 16
`define LRS_SEL_DD 2'h0
`define LRS_SEL_CG 2'h1
`define LRS_SEL_SEG 2'h2
`endif

// ===== rtl/lrs_cmd.v
// Instruction decoder and RAM access path of a character LCD controller
`timescale 1ns/10ps
`include "lrs_map.vh"
// Operation
// - Extended select set, top bit one: write takes a 6-bit scroll quantity.
// - Quantity zero no shift, 1-47 that many dots, upper bits both one 48.
// - Status read returns busy flag on bit 7, address counter below.
// - Data write stores the byte in the RAM chosen by last address set.
// - After a data write the address counter steps by one per entry mode.
// - Data read returns the prefetched output data register.
// - Cursor shift during display RAM access reloads the output data register.
// - After a data read the address counter steps by one per entry mode.
// - After a write the counter points onward; written data needs a read.
// - Clear fills display RAM with spaces, zeroes counter, within the long time.
// - Home zeroes counter and display shift, keeps display RAM.
// - Entry mode latches step direction and shift-on-write bits.
// - Basic code 0x08-0x0F sets display, cursor and blink enables.
// - Extended code 0x08-0x0F sets font width, cursor inversion, four lines.
// - Basic code 0x10-0x1F shifts display or cursor right or left.
// - Extended select from function set routes the shared codes.
// - Four line enables choose which lines the dot scroll applies to.
// - In 4-bit mode each transfer is two consecutive nibbles.
module lrs_cmd #(
  parameter integer T_LONG_CYC = (`LRS_T_LONG_NS + `LRS_CLK_NS - 1) / `LRS_CLK_NS,
  parameter integer T_SHORT_CYC = (`LRS_T_SHORT_NS + `LRS_CLK_NS - 1) / `LRS_CLK_NS,
  parameter integer T_DATA_CYC = (`LRS_T_DATA_NS + `LRS_CLK_NS - 1) / `LRS_CLK_NS
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_strobe,
  input wire i_register_select,
  input wire i_read,
  input wire [7:0] i_data,
  output reg [7:0] o_data,
  output reg o_busy_flag,
  output reg [6:0] o_address_counter,
  output reg o_extended_select,
  output reg o_bus_width_select,
  output reg o_increment,
  output reg o_shift_on_write,
  output reg o_display_on,
  output reg o_cursor_on,
  output reg o_blink_on,
  output reg o_font_width,
  output reg o_cursor_inversion,
  output reg o_four_line_mode,
  output reg [3:0] o_line_scroll_enable,
  output reg [5:0] o_scroll_dots,
  output reg [6:0] o_display_shift
);
  // -----------------------------------------------------------------
  // Storage and state
  // -----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CLEAR = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;
  reg [7:0] dd_ram [0:`LRS_DD_DEPTH-1];
  reg [7:0] cg_ram [0:`LRS_CG_DEPTH-1];
  reg [7:0] seg_ram [0:`LRS_SEG_DEPTH-1];
  reg [2:0] state;
  reg [21:0] busy_cnt;
  reg [1:0] ram_sel;
  reg [6:0] clr_idx;
  reg nib_hi;
  reg [3:0] nib_save;
  reg [7:0] next_data;
  reg prefetch;
  reg [7:0] out_data;
  wire [7:0] byte_in;
  wire byte_ok;
  wire [6:0] ac_step;
  reg [7:0] ram_rd;
  assign byte_in = o_bus_width_select ? i_data : {nib_save, i_data[7:4]};
  assign byte_ok = i_strobe & (o_bus_width_select | nib_hi);
  assign ac_step = o_increment ? o_address_counter + 7'h01 : o_address_counter - 7'h01;

  always @* begin
    case (ram_sel)
      `LRS_SEL_CG: ram_rd = cg_ram[o_address_counter[5:0]];
      `LRS_SEL_SEG: ram_rd = seg_ram[o_address_counter[3:0]];
      default: ram_rd = dd_ram[o_address_counter];
    endcase
  end

  // Display RAM, space fill during clear
  genvar gi;
  generate
    for (gi = 0; gi < `LRS_DD_DEPTH; gi = gi + 1) begin : g_dd
      always @(posedge i_clk) begin
        if (state == ST_CLEAR && clr_idx == gi)
          dd_ram[gi] <= `LRS_SPACE_CODE;
        else if (state == ST_IDLE && byte_ok && i_register_select && !i_read &&
                 ram_sel == `LRS_SEL_DD && o_address_counter == gi)
          dd_ram[gi] <= byte_in;
      end
    end
  endgenerate

  always @(posedge i_clk) begin
    if (state == ST_IDLE && byte_ok && i_register_select && !i_read) begin
      if (ram_sel == `LRS_SEL_CG)
        cg_ram[o_address_counter[5:0]] <= byte_in;
      if (ram_sel == `LRS_SEL_SEG)
        seg_ram[o_address_counter[3:0]] <= byte_in;
    end
  end

  // Read data mux for status and data reads
  always @* begin
    next_data = out_data;
    if (!i_register_select)
      next_data = {o_busy_flag, o_address_counter};
  end

  // -----------------------------------------------------------------
  // Decoder
  // -----------------------------------------------------------------
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_IDLE;
      busy_cnt <= 22'h00_0000;
      ram_sel <= `LRS_SEL_DD;
      clr_idx <= 7'h00;
      nib_hi <= 1'b0;
      nib_save <= 4'h0;
      prefetch <= 1'b0;
      out_data <= 8'h00;
      o_data <= 8'h00;
      o_busy_flag <= 1'b0;
      o_address_counter <= `LRS_AC_ZERO;
      o_extended_select <= 1'b0;
      o_bus_width_select <= 1'b1;
      o_increment <= 1'b1;
      o_shift_on_write <= 1'b0;
      o_display_on <= 1'b0;
      o_cursor_on <= 1'b0;
      o_blink_on <= 1'b0;
      o_font_width <= 1'b0;
      o_cursor_inversion <= 1'b0;
      o_four_line_mode <= 1'b0;
      o_line_scroll_enable <= 4'h0;
      o_scroll_dots <= 6'h00;
      o_display_shift <= 7'h00;
    end else begin
      prefetch <= 1'b0;
      // Status reads leave the prefetched byte intact
      if (prefetch)
        out_data <= ram_rd;
      if (i_strobe && !o_bus_width_select) begin
        nib_hi <= ~nib_hi;
        nib_save <= i_data[7:4];
      end
      // Data read answers from the output data register
      if (i_strobe && i_read && (!i_register_select || (state == ST_IDLE && byte_ok)))
        o_data <= next_data;
      case (state)
        ST_IDLE: begin
          if (byte_ok && i_register_select) begin
            o_busy_flag <= 1'b1;
            busy_cnt <= T_DATA_CYC[21:0];
            state <= ST_WAIT;
            o_address_counter <= ac_step;
            // Prefetched register answers, refill after step
            prefetch <= 1'b1;
            if (!i_read && o_shift_on_write && ram_sel == `LRS_SEL_DD)
              o_display_shift <= o_increment ? o_display_shift - 7'h01
                                             : o_display_shift + 7'h01;
          end else if (byte_ok && !i_read) begin
            o_busy_flag <= 1'b1;
            busy_cnt <= T_SHORT_CYC[21:0];
            state <= ST_WAIT;
            if (byte_in[7]) begin
              if (o_extended_select) begin
                o_scroll_dots <= (byte_in[5:4] == 2'b11) ? `LRS_SQ_MAX : byte_in[5:0];
              end else begin
                ram_sel <= `LRS_SEL_DD;
                o_address_counter <= byte_in[6:0];
                prefetch <= 1'b1;
              end
            end else if (byte_in[6]) begin
              ram_sel <= o_extended_select ? `LRS_SEL_SEG : `LRS_SEL_CG;
              o_address_counter <= o_extended_select ? {3'h0, byte_in[3:0]}
                                                     : {1'b0, byte_in[5:0]};
              prefetch <= 1'b1;
            end else if (byte_in[5]) begin
              o_bus_width_select <= byte_in[4];
              o_extended_select <= byte_in[2];
              nib_hi <= 1'b0;
            end else if (byte_in[4]) begin
              if (o_extended_select) begin
                o_line_scroll_enable <= byte_in[3:0];
              end else if (byte_in[3]) begin
                o_display_shift <= byte_in[2] ? o_display_shift + 7'h01
                                              : o_display_shift - 7'h01;
              end else begin
                o_address_counter <= byte_in[2] ? o_address_counter + 7'h01
                                                : o_address_counter - 7'h01;
                prefetch <= 1'b1;
              end
            end else if (byte_in[3]) begin
              if (o_extended_select) begin
                o_font_width <= byte_in[2];
                o_cursor_inversion <= byte_in[1];
                o_four_line_mode <= byte_in[0];
              end else begin
                o_display_on <= byte_in[2];
                o_cursor_on <= byte_in[1];
                o_blink_on <= byte_in[0];
              end
            end else if (byte_in[2]) begin
              o_increment <= byte_in[1];
              o_shift_on_write <= byte_in[0];
            end else if (byte_in[1]) begin
              busy_cnt <= T_LONG_CYC[21:0];
              o_address_counter <= `LRS_AC_ZERO;
              o_display_shift <= 7'h00;
              ram_sel <= `LRS_SEL_DD;
            end else if (byte_in[0]) begin
              busy_cnt <= T_LONG_CYC[21:0];
              o_address_counter <= `LRS_AC_ZERO;
              o_display_shift <= 7'h00;
              o_increment <= 1'b1;
              ram_sel <= `LRS_SEL_DD;
              clr_idx <= 7'h00;
              state <= ST_CLEAR;
            end
          end
        end
        ST_CLEAR: begin
          busy_cnt <= busy_cnt - 22'h00_0001;
          clr_idx <= clr_idx + 7'h01;
          if (clr_idx == `LRS_DD_DEPTH - 1)
            state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (busy_cnt <= 22'h00_0001) begin
            o_busy_flag <= 1'b0;
            state <= ST_IDLE;
          end else begin
            busy_cnt <= busy_cnt - 22'h00_0001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // lrs_cmd

// ===== verif/lrs_cmd_props.sv
// Concurrent checks on the command block ports
`timescale 1ns/10ps
module lrs_cmd_props (
  input wire i_clk,
  input wire i_nrst,
  input wire i_strobe,
  input wire i_register_select,
  input wire i_read,
  input wire [7:0] i_data,
  input wire [7:0] o_data,
  input wire o_busy_flag,
  input wire [6:0] o_address_counter,
  input wire o_extended_select,
  input wire o_bus_width_select,
  input wire o_increment,
  input wire o_shift_on_write,
  input wire o_display_on,
  input wire o_cursor_on,
  input wire o_blink_on,
  input wire [5:0] o_scroll_dots,
  input wire [6:0] o_display_shift
);
  wire go = i_strobe & !o_busy_flag & o_bus_width_select;
  wire ins = go & !i_read & !i_register_select;
  wire [6:0] stp = o_increment ? 7'h01 : 7'h7f;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  status_read_a: assert property (i_strobe & !i_register_select & i_read
    |=> o_data == {$past(o_busy_flag), $past(o_address_counter)}) else $error("bad status");
  busy_rise_a: assert property (ins |=> o_busy_flag) else $error("no busy");
  scroll_dots_a: assert property (ins & o_extended_select & i_data[7]
    |=> o_scroll_dots == (&$past(i_data[5:4]) ? 6'h30 : $past(i_data[5:0])))
    else $error("bad scroll");
  write_step_a: assert property (go & !i_read & i_register_select
    |=> o_address_counter == $past(o_address_counter) + $past(stp))
    else $error("bad write step");
  read_step_a: assert property (go & i_read & i_register_select
    |=> o_address_counter == $past(o_address_counter) + $past(stp))
    else $error("bad read step");
  clear_ac_a: assert property (ins & (i_data == 8'h01)
    |=> ##[0:2] o_address_counter == 7'h00) else $error("bad clear");
  home_zero_a: assert property (ins & (i_data[7:1] == 7'h01)
    |=> ##[0:2] (o_address_counter == 7'h00 && o_display_shift == 7'h00)) else $error("bad home");
  entry_mode_a: assert property (ins & (i_data[7:2] == 6'h01)
    |=> {o_increment, o_shift_on_write} == $past(i_data[1:0])) else $error("bad entry");
  onoff_bits_a: assert property (ins & !o_extended_select & (i_data[7:3] == 5'h01)
    |=> {o_display_on, o_cursor_on, o_blink_on} == $past(i_data[2:0])) else $error("bad on");
endmodule // lrs_cmd_props
bind lrs_cmd lrs_cmd_props chk (.i_clk, .i_nrst, .i_strobe, .i_register_select, .i_read,
  .i_data, .o_data, .o_busy_flag, .o_address_counter, .o_extended_select, .o_bus_width_select,
  .o_increment, .o_shift_on_write, .o_display_on, .o_cursor_on, .o_blink_on, .o_scroll_dots,
  .o_display_shift);

// ===== verif/lrs_host.sv
// Host bus model driving the command block
`timescale 1ns/10ps
module lrs_host (
  input wire i_clk,
  input wire [7:0] i_rdata,
  output reg o_strobe,
  output reg o_rs,
  output reg o_rd,
  output reg [7:0] o_wdata
);
  reg [7:0] q;
  reg [7:0] dat;
  integer n;
  reg nib4;
  initial {o_strobe, o_rs, o_rd, o_wdata} = 11'h000;
  initial nib4 = 1'b0;
  // Read answer taken two falling edges after the last strobe
  task xfer(input r, input w, input [7:0] d);
    begin
      @(negedge i_clk);
      // Two nibble transfers in 4-bit mode
      if (nib4) begin
        // Upper nibble first, on upper lines
        {o_strobe, o_rs, o_rd, o_wdata} = {1'b1, r, w, d[7:4], 4'h0};
        @(negedge i_clk);
        o_strobe = 1'b0;
        @(negedge i_clk);
        {o_strobe, o_wdata} = {1'b1, d[3:0], 4'h0};
      end else begin
        {o_strobe, o_rs, o_rd, o_wdata} = {1'b1, r, w, d};
      end
      @(negedge i_clk);
      o_strobe = 1'b0;
      o_wdata = ~d;
      @(negedge i_clk);
      q = i_rdata;
      @(negedge i_clk);
    end
  endtask
  task op(input r, input w, input [7:0] d);
    begin
      xfer(r, w, d);
      dat = q;
      // Bus width follows own function set
      if (!r && !w && d[7:5] == 3'b001)
        nib4 = !d[4];
      n = 0;
      while ((r | !w) && n < 300) begin
        xfer(1'b0, 1'b1, 8'h00);
        n = (q[7] === 1'b0) ? 999 : n + 1;
      end
      if (n == 300) begin
        tb.n_mismatch = tb.n_mismatch + 1;
        tb.end_sim;
      end
    end
  endtask
endmodule // lrs_host

// ===== verif/tb.sv
// Self-checking bench for the command block
`timescale 1ns/10ps
module tb;
  reg i_clk;
  reg i_nrst;
  wire strobe, rs, rd;
  wire [7:0] wdata, o_data;
  integer n_mismatch, total_checks, i;
  lrs_cmd #(.T_LONG_CYC(200), .T_SHORT_CYC(20), .T_DATA_CYC(20)) uut (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_strobe(strobe), .i_register_select(rs), .i_read(rd), .i_data(wdata),
    .o_data(o_data), .o_busy_flag(), .o_address_counter(), .o_extended_select(),
    .o_bus_width_select(), .o_increment(), .o_shift_on_write(), .o_display_on(),
    .o_cursor_on(), .o_blink_on(), .o_font_width(), .o_cursor_inversion(),
    .o_four_line_mode(), .o_line_scroll_enable(), .o_scroll_dots(), .o_display_shift());
  lrs_host host (.i_clk(i_clk), .i_rdata(o_data), .o_strobe(strobe), .o_rs(rs), .o_rd(rd),
    .o_wdata(wdata));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task chk(input [7:0] g, input [7:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task ins(input [7:0] d);
    host.op(1'b0, 1'b0, d);
  endtask
  task wrd(input [7:0] d);
    host.op(1'b1, 1'b0, d);
  endtask
  task rdd(input [7:0] e);
    begin
      host.op(1'b1, 1'b1, 8'h00);
      chk(host.dat, e);
    end
  endtask
  task st(input [7:0] e);
    begin
      host.op(1'b0, 1'b1, 8'h00);
      chk(host.dat, e);
    end
  endtask
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    i_nrst = 1'b0;
    repeat (12) @(negedge i_clk);
    i_nrst = 1'b1;
    chk({uut.o_bus_width_select, uut.o_increment, uut.o_extended_select, 5'h00}, 8'hc0);
    ins(8'h34);
    ins(8'h0e);
    chk({5'h00, uut.o_font_width, uut.o_cursor_inversion, uut.o_four_line_mode}, 8'h06);
    ins(8'h1a);
    chk({4'h0, uut.o_line_scroll_enable}, 8'h0a);
    for (i = 0; i < 64; i = i + 1) begin
      if (i < 2 || i > 45) begin
        ins({1'b1, i[0], i[5:0]});
        chk({2'b00, uut.o_scroll_dots}, (i > 47) ? 8'h30 : i[7:0]);
      end
    end
    ins(8'h30);
    ins(8'h0d);
    chk({5'h00, uut.o_display_on, uut.o_cursor_on, uut.o_blink_on}, 8'h05);
    ins(8'h06);
    ins(8'h85);
    wrd(8'h41);
    wrd(8'h42);
    st(8'h07);
    ins(8'h85);
    rdd(8'h41);
    rdd(8'h42);
    ins(8'h04);
    ins(8'h86);
    wrd(8'h55);
    st(8'h05);
    ins(8'h14);
    st(8'h06);
    rdd(8'h55);
    st(8'h05);
    ins(8'h43);
    wrd(8'h1f);
    ins(8'h43);
    rdd(8'h1f);
    ins(8'h34);
    ins(8'h42);
    wrd(8'h0a);
    ins(8'h42);
    rdd(8'h0a);
    ins(8'h30);
    ins(8'h85);
    ins(8'h18);
    chk({7'h00, |uut.o_display_shift}, 8'h01);
    ins(8'h02);
    chk({1'b0, uut.o_display_shift}, 8'h00);
    st(8'h00);
    ins(8'h85);
    rdd(8'h41);
    ins(8'h07);
    chk({7'h00, uut.o_shift_on_write}, 8'h01);
    wrd(8'h33);
    chk({1'b0, uut.o_display_shift}, 8'h7f);
    host.xfer(1'b0, 1'b0, 8'h01);
    host.xfer(1'b0, 1'b0, 8'h08);
    st(8'h80);
    ins(8'h06);
    chk({5'h00, uut.o_display_on, uut.o_cursor_on, uut.o_blink_on}, 8'h05);
    st(8'h00);
    ins(8'h85);
    rdd(8'h20);
    ins(8'h20);
    ins(8'h0b);
    chk({5'h00, uut.o_display_on, uut.o_cursor_on, uut.o_blink_on}, 8'h03);
    ins(8'h85);
    wrd(8'h5a);
    ins(8'h85);
    rdd(8'h5a);
    st(8'h06);
    end_sim;
  end
endmodule // tb
